// >>> core/sequence_step_controller.sv
// Step sequencer driving a waveform synthesizer, with AXI4-Lite registers
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module sequence_step_controller (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// AXI4-Lite write channels
	input wire logic [seq_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels
	input wire logic [seq_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Branch pins, asynchronous
	input wire logic immediate_branch_i,
	input wire logic level_branch_i,
	// Synthesizer side
	output seq_pkg::chan_type chan_o,
	output logic [15:0] ref_phase_o,
	output logic [seq_pkg::STEP_W-1:0] step_o,
	output logic [3:0] step_sync_code_o,
	output seq_pkg::seq_state_type seq_state_o
);
	import seq_pkg::*;

	function automatic logic step_area(input logic [ADDR_W-1:0] a);
		step_area = (a[11:9] == STEP_AREA_SEL);
	endfunction : step_area

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		reg_mapped = step_area(a) || a == CMD_ADDR || a == STATUS_ADDR
			|| a == START_STEP_ADDR;
	endfunction : reg_mapped

	function automatic logic gateable(input wave_type w);
		gateable = (w == WAVE_SINE) || (w == WAVE_ARB);
	endfunction : gateable

	function automatic logic resets_ref(input wave_type w);
		resets_ref = (w == WAVE_ARB) || (w == WAVE_DC) || (w == WAVE_NOISE);
	endfunction : resets_ref

	logic [31:0] mem [MEM_WORDS];
	seq_state_type state_q, state_d;
	logic [STEP_W-1:0] step_q, dest_q, dest_d, go_step, start_step_q;
	logic [31:0] elapsed_q, ref_q;
	logic [3:0] lat_q, cmd_q, code_q;
	wave_type wave_q;
	logic [31:0] cur_q [NPARAM];
	logic [31:0] start_q [NPARAM];
	logic [31:0] val_d [NPARAM];
	logic [31:0] tgt_w [NPARAM];
	logic go;
	chan_type chan_q;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
	logic arready_q, rvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;

	wire aw_take = s_axi_awvalid_i & awready_q;
	wire w_take = s_axi_wvalid_i & wready_q;
	wire wr_do = aw_full_q & w_full_q & ~bvalid_q;
	wire aw_full_d = (aw_full_q | aw_take) & ~wr_do;
	wire w_full_d = (w_full_q | w_take) & ~wr_do;
	wire ar_take = s_axi_arvalid_i & arready_q;
	wire rvalid_d = (rvalid_q & ~s_axi_rready_i) | ar_take;
	wire wr_step = step_area(aw_addr_q);
	wire [6:0] wr_idx = aw_addr_q[8:2];
	wire [6:0] rd_idx = s_axi_araddr_i[8:2];
	wire [31:0] status_w = {18'h0, state_q, 4'h0, step_q};
	wire [31:0] rd_word = step_area(s_axi_araddr_i) ? mem[rd_idx]
		: (s_axi_araddr_i == STATUS_ADDR) ? status_w
		: (s_axi_araddr_i == START_STEP_ADDR) ? {28'h0, start_step_q}
		: 32'h0;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= ~aw_full_d;
			wready_q <= ~w_full_d;
			if (aw_take)
				aw_addr_q <= s_axi_awaddr_i;
			if (w_take)
			begin
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (wr_do)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= reg_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready_i)
				bvalid_q <= 1'b0;
			rvalid_q <= rvalid_d;
			arready_q <= ~rvalid_d;
			if (ar_take)
			begin
				rdata_q <= rd_word;
				rresp_q <= reg_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Step table storage and command pulses
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < MEM_WORDS; i++)
				mem[i] <= 32'h0;
			cmd_q <= 4'h0;
			start_step_q <= START_STEP_RST;
		end
		else
		begin
			cmd_q <= (wr_do && aw_addr_q == CMD_ADDR && w_strb_q[0])
				? w_data_q[3:0] : 4'h0;
			if (wr_do && aw_addr_q == START_STEP_ADDR && w_strb_q[0])
				start_step_q <= w_data_q[STEP_W-1:0];
			for (int b = 0; b < 4; b++)
				if (wr_do && wr_step && w_strb_q[b])
					mem[wr_idx][8*b +: 8] <= w_data_q[8*b +: 8];
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic imm_s1_q, imm_s2_q, imm_s3_q, lvl_s1_q, lvl_s2_q;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			imm_s1_q <= 1'b0;
			imm_s2_q <= 1'b0;
			imm_s3_q <= 1'b0;
			lvl_s1_q <= 1'b0;
			lvl_s2_q <= 1'b0;
		end
		else
		begin
			imm_s1_q <= immediate_branch_i;
			imm_s2_q <= imm_s1_q;
			imm_s3_q <= imm_s2_q;
			lvl_s1_q <= level_branch_i;
			lvl_s2_q <= lvl_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Current step decode
	// ------------------------------------------------------------
	wire step_ctrl_type ctl = step_ctrl_type'(mem[{step_q, 3'(F_CTRL)}]);
	wire [31:0] dur = mem[{step_q, 3'(F_DUR)}];
	wire [15:0] stop_ph = mem[{step_q, 3'(F_STOP)}][15:0];
	wire [31:0] act_word = mem[{step_q, 3'(F_ACT)}];
	wire start_cmd = cmd_q[CMD_START];
	wire stop_cmd = cmd_q[CMD_STOP];
	wire resume_cmd = cmd_q[CMD_RESUME];
	wire imm = cmd_q[CMD_BRANCH] | (imm_s2_q & ~imm_s3_q);
	wire expired = (elapsed_q >= dur);
	wire [31:0] e1 = expired ? elapsed_q : elapsed_q + 32'h1;
	wire gate_on = ctl.phase_gate_select & gateable(ctl.wave);
	// Arbitrary steps gate on their own phase setting
	wire [31:0] gate_tgt = (ctl.wave == WAVE_ARB) ? cur_q[P_PHASE]
		: {stop_ph, 16'h0};
	wire [31:0] ref_next = ref_q + cur_q[P_FREQ];
	wire gate_hit = (ref_next - gate_tgt) < (ref_q - gate_tgt);
	wire [STEP_W-1:0] next_seq = ctl.step_termination_choice ? '0
		: step_q + STEP_W'(1);
	wire [STEP_W-1:0] after_time = (ctl.level_branch_en && lvl_s2_q)
		? ctl.level_target : next_seq;

	// ------------------------------------------------------------
	// Channel parameter actions
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NPARAM; g++)
		begin : g_param
			wire [31:0] tgt = mem[{step_q, 3'(F_VAL + g)}];
			wire [1:0] act = act_word[2*g +: 2];
			wire signed [65:0] diff =
				66'(signed'(tgt)) - 66'(signed'(start_q[g]));
			wire signed [65:0] prod = diff * signed'({34'h0, e1});
			wire signed [65:0] quot = (dur == 32'h0) ? diff
				: prod / signed'({34'h0, dur});
			wire [31:0] swept = start_q[g] + quot[31:0];
			assign tgt_w[g] = tgt;
			assign val_d[g] = (act == ACT_SWEEP) ? swept
				: (act == ACT_KEEP && step_q != '0) ? start_q[g]
				: tgt;
		end
	endgenerate

	// ------------------------------------------------------------
	// Sequencer state machine
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		dest_d = dest_q;
		go = 1'b0;
		go_step = step_q;
		case (state_q)
			S_IDLE:
				if (start_cmd)
				begin
					dest_d = start_step_q;
					if (gate_on)
						state_d = S_GATE;
					else
					begin
						go = 1'b1;
						go_step = start_step_q;
					end
				end
			S_RUN:
				if (imm)
				begin
					go = 1'b1;
					go_step = ctl.branch_target;
				end
				else if (stop_cmd)
				begin
					go = 1'b1;
					go_step = '0;
				end
				else if (expired)
				begin
					dest_d = after_time;
					if (ctl.pause_after_step)
						state_d = S_PAUSE;
					else if (gate_on)
						state_d = S_GATE;
					else
					begin
						go = 1'b1;
						go_step = after_time;
					end
				end
			S_GATE, S_LAT:
				if (imm)
				begin
					go = 1'b1;
					go_step = ctl.branch_target;
				end
				else if (stop_cmd)
				begin
					go = 1'b1;
					go_step = '0;
				end
				else if (state_q == S_GATE && gate_hit)
					state_d = S_LAT;
				else if (state_q == S_LAT && lat_q == LAT_LAST)
				begin
					go = 1'b1;
					go_step = dest_q;
				end
			S_PAUSE:
				if (imm)
				begin
					go = 1'b1;
					go_step = ctl.branch_target;
				end
				else if (stop_cmd || resume_cmd)
				begin
					go = 1'b1;
					go_step = stop_cmd ? '0 : next_seq;
				end
			S_END0:
				if (expired)
					state_d = S_IDLE;
			default:
				state_d = S_IDLE;
		endcase
		if (go)
			state_d = (go_step == '0) ? S_END0 : S_RUN;
	end

	wire step_active = (state_q == S_RUN) || (state_q == S_END0);
	wire step_ctrl_type go_ctl = step_ctrl_type'(mem[{go_step, 3'(F_CTRL)}]);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= S_IDLE;
			step_q <= '0;
			dest_q <= '0;
			elapsed_q <= 32'h0;
			lat_q <= 4'h0;
			ref_q <= 32'h0;
			wave_q <= WAVE_SINE;
			code_q <= 4'h0;
			for (int p = 0; p < NPARAM; p++)
			begin
				cur_q[p] <= 32'h0;
				start_q[p] <= 32'h0;
			end
		end
		else
		begin
			state_q <= state_d;
			dest_q <= dest_d;
			code_q <= ctl.step_sync_code;
			lat_q <= (state_q == S_LAT) ? lat_q + 4'h1 : 4'h0;
			// Phase runs on unless leaving an arbitrary, DC or noise step
			ref_q <= (go && resets_ref(wave_q)) ? 32'h0
				: ref_next;
			if (go)
			begin
				step_q <= go_step;
				elapsed_q <= 32'h0;
				wave_q <= go_ctl.wave;
				for (int p = 0; p < NPARAM; p++)
					start_q[p] <= cur_q[p];
			end
			else if (state_q == S_IDLE)
			begin
				wave_q <= ctl.wave;
				for (int p = 0; p < NPARAM; p++)
					cur_q[p] <= tgt_w[p];
			end
			else if (step_active)
			begin
				elapsed_q <= e1;
				for (int p = 0; p < NPARAM; p++)
					cur_q[p] <= val_d[p];
			end
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			chan_q <= '0;
		else
		begin
			chan_q.wave <= wave_q;
			chan_q.freq <= cur_q[P_FREQ];
			chan_q.ampl <= cur_q[P_AMPL];
			chan_q.offs <= cur_q[P_OFFS];
			chan_q.phase <= ref_q + cur_q[P_PHASE];
		end
	end

	assign chan_o = chan_q;
	assign ref_phase_o = ref_q[31:16];
	assign step_o = step_q;
	assign step_sync_code_o = code_q;
	assign seq_state_o = state_q;
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_start_first_step: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_IDLE && start_cmd && !gate_on && start_step_q != '0)
		|=> (state_q == S_RUN && step_q == $past(start_step_q)))
		else $error("start did not reach the start step");

	a_continue_next: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_RUN && expired && !imm && !stop_cmd && !gate_on
		&& !ctl.pause_after_step && !ctl.step_termination_choice
		&& !ctl.level_branch_en && step_q != '1)
		|=> step_q == $past(step_q) + STEP_W'(1))
		else $error("continue did not advance one step");

	a_pause_hold: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_RUN && expired && ctl.pause_after_step
		&& !imm && !stop_cmd)
		|=> state_q == S_PAUSE ##1 $stable(cur_q[P_OFFS]))
		else $error("pause flag did not hold the step");

	a_paused_stop: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_PAUSE && stop_cmd && !imm)
		|=> (state_q == S_END0 && step_q == '0))
		else $error("stop while paused missed step 0");

	a_resume_end: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_PAUSE && resume_cmd && !stop_cmd && !imm
		&& ctl.step_termination_choice) |=> state_q == S_END0)
		else $error("resume of an end step missed step 0");

	a_gate_latency: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_GATE && gate_hit && !imm && !stop_cmd)
		|=> (state_q == S_LAT && !go)[*8])
		else $error("step changed too soon after stop phase");

	a_gate_freeze: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_GATE && $past(state_q) == S_GATE)
		|-> ($stable(cur_q[P_AMPL]) && $stable(cur_q[P_FREQ])))
		else $error("output changed while waiting for phase");

	a_sweep_end: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_RUN && $past(state_q) == S_RUN && expired
		&& $stable(step_q) && dur != 32'h0
		&& act_word[2*P_OFFS +: 2] == ACT_SWEEP)
		|-> cur_q[P_OFFS] == tgt_w[P_OFFS])
		else $error("sweep missed its target at expiry");

	a_fixed_value: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(state_q == S_RUN && $past(state_q) == S_RUN && $stable(step_q)
		&& act_word[2*P_OFFS +: 2] == ACT_FIXED)
		|-> cur_q[P_OFFS] == tgt_w[P_OFFS])
		else $error("fixed value not applied");

	a_ref_restart: assert property (@(posedge clk_i)
		disable iff (!reset_n_i)
		(go && resets_ref(wave_q)) |=> ref_q == 32'h0)
		else $error("reference phase did not restart");

endmodule : sequence_step_controller

`default_nettype wire

// >>> core/seq_pkg.sv
// Constants, field layouts and carrier types of the step sequencer
package seq_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] CMD_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [11:0] START_STEP_ADDR = 12'h008;
	localparam logic [2:0] STEP_AREA_SEL = 3'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Step table layout
	// ------------------------------------------------------------
	localparam int STEP_W = 4;
	localparam int NSTEP = 16;
	localparam int WORDS_PER_STEP = 8;
	localparam int MEM_WORDS = NSTEP * WORDS_PER_STEP;
	localparam int F_CTRL = 0;
	localparam int F_DUR = 1;
	localparam int F_STOP = 2;
	localparam int F_ACT = 3;
	localparam int F_VAL = 4;
	localparam int NPARAM = 4;
	localparam int P_FREQ = 0;
	localparam int P_AMPL = 1;
	localparam int P_OFFS = 2;
	localparam int P_PHASE = 3;
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_RESUME = 2;
	localparam int CMD_BRANCH = 3;
	localparam logic [3:0] START_STEP_RST = 4'h1;

	// ------------------------------------------------------------
	// Encodings and timing
	// ------------------------------------------------------------
	localparam logic [1:0] ACT_FIXED = 2'h0;
	localparam logic [1:0] ACT_KEEP = 2'h1;
	localparam logic [1:0] ACT_SWEEP = 2'h2;
	localparam int CLK_PERIOD_NS = 50;
	localparam int GATE_LAT_NS = 650;
	localparam int GATE_LAT_CYC =
		(GATE_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] LAT_LAST = 4'(GATE_LAT_CYC - 1);

	typedef enum logic [2:0] {
		WAVE_SINE = 3'h0,
		WAVE_SQUARE = 3'h1,
		WAVE_NOISE = 3'h2,
		WAVE_DC = 3'h3,
		WAVE_ARB = 3'h4
	} wave_type;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_RUN = 6'h02,
		S_GATE = 6'h04,
		S_LAT = 6'h08,
		S_PAUSE = 6'h10,
		S_END0 = 6'h20
	} seq_state_type;

	typedef struct packed {
		logic [7:0] rsv_hi;
		logic [3:0] level_target;
		logic [3:0] branch_target;
		logic [4:0] rsv_lo;
		wave_type wave;
		logic [3:0] step_sync_code;
		logic level_branch_en;
		logic phase_gate_select;
		logic step_termination_choice;
		logic pause_after_step;
	} step_ctrl_type;

	typedef struct packed {
		wave_type wave;
		logic [31:0] freq;
		logic [31:0] ampl;
		logic [31:0] offs;
		logic [31:0] phase;
	} chan_type;

endpackage : seq_pkg

// >>> testbench/synth_model.sv
// Behavioural synthesizer datapath watching the sequencer outputs
`timescale 1ns/1ps
`default_nettype none

module synth_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Settings from the sequencer
	input wire seq_pkg::chan_type chan_i,
	input wire logic [seq_pkg::STEP_W-1:0] step_i,
	// Offset seen on the first cycle of each step
	output logic [31:0] entry_offs_o
);
	import seq_pkg::*;

	logic [STEP_W-1:0] prev_q;

	// Latch the offset the datapath was given at each step change
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			prev_q <= '0;
			entry_offs_o <= '0;
		end
		else
		begin
			prev_q <= step_i;
			if (step_i != prev_q)
				entry_offs_o <= chan_i.offs;
		end
	end
endmodule : synth_model

`default_nettype wire

// >>> testbench/sequence_step_controller_tb_top.sv
// Self-checking bench of the step sequencer
`timescale 1ns/1ps
`default_nettype none

module sequence_step_controller_tb_top;
	import seq_pkg::*;

	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d, entry_offs;
	logic imm_br = 1'b0;
	logic lvl_br = 1'b0;
	chan_type chan;
	logic [15:0] ref_ph;
	logic [3:0] step, code;
	seq_state_type state;
	int err_total = 0;
	int num_checks = 0;
	int cyc;

	always #(CLK_PERIOD_NS/2) clk_i = ~clk_i;

	sequence_step_controller dut_u (
		.clk_i(clk_i), .reset_n_i(reset_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .immediate_branch_i(imm_br),
		.level_branch_i(lvl_br), .chan_o(chan), .ref_phase_o(ref_ph),
		.step_o(step), .step_sync_code_o(code), .seq_state_o(state)
	);

	synth_model model_u (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .chan_i(chan),
		.step_i(step), .entry_offs_o(entry_offs)
	);

	// ------------------------------------------------------------
	// Bus and check helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		bit aw, w;
		int n;
		aw = 1'b0;
		w = 1'b0;
		r = 2'h3;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100 && r === 2'h3; n++)
		begin
			@(posedge clk_i);
			if (!aw && awready)
			begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
			end
		end
		@(posedge clk_i);
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a);
		bit ar;
		int n;
		ar = 1'b0;
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100 && r === 2'h3; n++)
		begin
			@(posedge clk_i);
			if (!ar && arready)
			begin
				ar = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid)
			begin
				r = rresp;
				d = rdata;
				rready <= 1'b0;
			end
		end
		@(posedge clk_i);
	endtask : axi_rd

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		axi_wr(a, v);
		chk(32'(r), 32'(RESP_OKAY));
	endtask : wr

	task automatic wait_for(input logic [3:0] s, input seq_state_type st);
		cyc = 0;
		while (cyc < 400 && !(step === s && state === st))
		begin
			@(posedge clk_i);
			cyc++;
		end
		chk({22'h0, state, step}, {22'h0, st, s});
	endtask : wait_for

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic reset_test;
		axi_rd(START_STEP_ADDR);
		chk(d, 32'h1);
		axi_rd(STATUS_ADDR);
		chk(d, 32'h0000_0100);
		axi_rd(12'h100);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_wr(12'h100, 32'hFFFF_FFFF);
		chk(32'(r), 32'(RESP_SLVERR));
	endtask : reset_test

	task automatic program_table;
		logic [31:0] tbl [4][5];
		// Columns: control, duration, stop phase, actions, offset
		tbl = '{'{32'h0000_03A0, 32'h8, 32'h0, 32'h20, 32'h08},
			'{32'h0003_0310, 32'h14, 32'h0, 32'h20, 32'h40},
			'{32'h0000_0320, 32'h2, 32'h0, 32'h10, 32'h77},
			'{32'h0000_0333, 32'h2, 32'h0, 32'h0, 32'h10}};
		for (int s = 0; s < 4; s++)
			for (int w = 0; w < 4; w++)
				wr(12'(12'h200 + s * 32 + w * 4), tbl[s][w]);
		for (int s = 0; s < 4; s++)
			wr(12'(12'h218 + s * 32), tbl[s][4]);
		repeat (3) @(posedge clk_i);
		chk(chan.offs, 32'h08);
	endtask : program_table

	task automatic run_once_test;
		wr(CMD_ADDR, 32'h1 << CMD_START);
		wait_for(4'h1, S_RUN);
		repeat (2) @(posedge clk_i);
		chk(32'(code), 32'h1);
		chk(32'(chan.wave), 32'(WAVE_DC));
		wait_for(4'h2, S_RUN);
		repeat (2) @(posedge clk_i);
		chk(chan.offs, 32'h40);
		chk(entry_offs, 32'h40);
		wait_for(4'h3, S_RUN);
		repeat (2) @(posedge clk_i);
		chk(chan.offs, 32'h10);
		wait_for(4'h3, S_PAUSE);
		repeat (4) @(posedge clk_i);
		chk({28'h0, step}, 32'h3);
		chk(chan.offs, 32'h10);
		wr(CMD_ADDR, 32'h1 << CMD_RESUME);
		wait_for(4'h0, S_END0);
		repeat (2) @(posedge clk_i);
		chk(32'(chan.offs > 32'h8 && chan.offs < 32'h10), 32'h1);
		wait_for(4'h0, S_IDLE);
		chk(chan.offs, 32'h08);
	endtask : run_once_test

	task automatic branch_stop_test;
		wr(CMD_ADDR, 32'h1 << CMD_START);
		wait_for(4'h1, S_RUN);
		imm_br <= 1'b1;
		repeat (3) @(posedge clk_i);
		imm_br <= 1'b0;
		wait_for(4'h3, S_RUN);
		chk(32'(cyc < 12), 32'h1);
		wait_for(4'h3, S_PAUSE);
		wr(CMD_ADDR, 32'h1 << CMD_STOP);
		wait_for(4'h0, S_END0);
		wait_for(4'h0, S_IDLE);
	endtask : branch_stop_test

	// Step 1 sine gated at half cycle, step 2 takes the level branch
	task automatic gate_level_test;
		wr(12'h220, 32'h0000_0014);
		wr(12'h228, 32'h0000_8000);
		wr(12'h230, 32'h1000_0000);
		wr(12'h240, 32'h0000_0328);
		lvl_br <= 1'b1;
		wr(CMD_ADDR, 32'h1 << CMD_START);
		wait_for(4'h1, S_LAT);
		chk(32'(ref_ph), 32'h0000_8000);
		wait_for(4'h2, S_RUN);
		chk(32'(cyc), 32'(GATE_LAT_CYC));
		wait_for(4'h0, S_END0);
		wait_for(4'h0, S_IDLE);
	endtask : gate_level_test

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1;
		@(posedge clk_i);
		reset_test();
		program_table();
		run_once_test();
		branch_stop_test();
		gate_level_test();
		finish_test();
	end

	initial
	begin
		repeat (8000) @(posedge clk_i);
		err_total++;
		finish_test();
	end
endmodule : sequence_step_controller_tb_top

`default_nettype wire
